// [rtl/fwp_lock_mem.sv]
// Per-sector lock and lock-down bit store with a registered read port.
// Assumes one write per cycle; reset clears every bit as at power cycle.
`timescale 1ns/1ps
module fwp_lock_mem
	import fwp_pkg::*;
#(
	parameter int DEPTH = NUM_SECTORS,
	parameter int AW = SECT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [AW-1:0] raddr,
	output logic [1:0] rdata,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [1:0] wdata
);
	logic [1:0] mem_ff [DEPTH];

	// Flops rather than a RAM so reset can wipe all locks at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= 2'h0;
			end
			rdata <= 2'h0;
		end else begin
			if (we) begin
				mem_ff[waddr] <= wdata;
			end
			rdata <= mem_ff[raddr];
		end
	end
endmodule // fwp_lock_mem

// [rtl/fwp_pkg.sv]
// Shared constants for the flash write-protection checker.
// Assumes a 27-bit byte address into a 1Gb array built from four dies.
package fwp_pkg;
	localparam int ADDR_W = 27;
	localparam int SECT_W = 11;
	localparam int NUM_SECTORS = 2048;
	localparam int SECT_LSB = 16;
	localparam int SUB_LSB = 12;
	localparam int PAGE_LSB = 8;
	localparam int DIE_LSB = 25;
	localparam int SEG_LSB = 24;
	localparam int OTP_BYTES = 64;
	localparam int OTP_AW = 6;
	localparam int SECTS_PER_DIE = 512;
	localparam int SECTS_PER_DIE_W = 9;
	localparam logic [3:0] CODE_ALL = 4'hc;
	localparam logic [3:0] CODE_MAXPART = 4'hb;
	// Power-on inhibit time in ns and the cycle count derived from it.
	localparam int POR_NS = 100000;
	localparam int CLK_NS = 5;
	localparam int POR_CYCLES = (POR_NS + CLK_NS - 1) / CLK_NS;
	// APB register byte addresses.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_LOCK = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_DIAG = 8'h14;
	// Control register fields.
	localparam int CTRL_CODE_LSB = 0;
	localparam int CTRL_TB_BIT = 4;
	localparam int CTRL_WEL_BIT = 5;
	localparam int CTRL_WPN_BIT = 6;
	localparam logic [31:0] CTRL_RST = 32'h0000_0040;
	// Command register fields: opcode in [2:0], clock count in [15:8].
	localparam int CMD_CLK_LSB = 8;
	typedef enum logic [2:0] {
		FWP_OP_PROG, FWP_OP_SUB_ERASE, FWP_OP_SECT_ERASE, FWP_OP_DIE_ERASE,
		FWP_OP_LOCK_WR, FWP_OP_REG_WR, FWP_OP_PAGE_ERASE, FWP_OP_OTP_PROG
	} fwp_op_t;
	typedef enum logic [2:0] {
		FWP_RES_OK, FWP_RES_NO_WEL, FWP_RES_BITS, FWP_RES_POR,
		FWP_RES_PROT, FWP_RES_LOCKDN, FWP_RES_BAD
	} fwp_res_t;
endpackage : fwp_pkg

// [rtl/fwp_top.sv]
// Write-protection and geometry checker for a stacked serial NOR array.
// Assumes an APB master; commands arrive as register writes after decode.
`timescale 1ns/1ps
// Operation
// - Program only clears bits; erase alone returns bits to one; an accepted register write also strobes all-ones data.
// - Erase by subsector, sector or die; page erase is rejected.
// - Address splits into 2048 64KB sectors, 4KB subsectors, 256-byte pages.
// - 64-byte OTP area is outside array addressing.
// - Die and segment come from the top address bits.
// - Modifying command needs whole-byte clock count, else discarded.
// - Modifying commands ignored unless write enable latch is set.
// - Power-on timer inhibits all modification until it expires.
// - Sector write-lock bit set refuses program and erase there.
// - Lock-down bit freezes sector lock state until reset.
// - Only lock write command changes locks; refused when locked down.
// - Top/bottom 0: codes 1-11 protect top 2^(code-1) sectors; 12+ all.
// - Top/bottom 1: codes 1-11 protect bottom 2^(code-1) sectors; 12+ all.
// - Write-protect pin low locks the block-protect area.
module fwp_top
	import fwp_pkg::*;
#(
	parameter int POR_CNT = POR_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] old_data,
	input wire logic [7:0] new_data,
	input wire logic wp_n,
	output logic exec_ff,
	output logic [7:0] wr_data_ff
);
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SCAN, ST_DONE} fwp_state_t;

	fwp_state_t state_ff;
	logic [31:0] ctrl_ff;
	logic [2:0] op_ff;
	logic [7:0] clk_cnt_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [1:0] lock_wdata_ff;
	fwp_res_t res_ff;
	logic [31:0] por_ff;
	logic [SECTS_PER_DIE_W-1:0] scan_ff;
	logic scan_last_ff;
	logic [1:0] lock_rd;
	logic busy;

	// Bus decode; every access completes in its first access cycle.
	wire bus_acc = psel && penable;
	wire bus_wr = bus_acc && pwrite;
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_cmd = paddr == REG_CMD;
	wire hit_addr = paddr == REG_ADDR;
	wire hit_lock = paddr == REG_LOCK;
	wire hit_stat = paddr == REG_STAT;
	wire hit_diag = paddr == REG_DIAG;
	wire hit_any = hit_ctrl | hit_cmd | hit_addr | hit_lock | hit_stat | hit_diag;
	assign pready = 1'b1;
	assign pslverr = bus_acc && !hit_any;
	wire start = bus_wr && hit_cmd && !busy;

	// Geometry decode of the held address.
	wire [SECT_W-1:0] sector = addr_ff[ADDR_W-1:SECT_LSB];
	wire [1:0] die = addr_ff[ADDR_W-1:DIE_LSB];
	wire segment = addr_ff[SEG_LSB];
	wire [SECT_W-1:0] die_base = {die, {SECTS_PER_DIE_W{1'b0}}};
	wire [SECT_W-1:0] cur_sect = (op_ff == FWP_OP_DIE_ERASE) ?
		(die_base | {2'h0, scan_ff}) : sector;

	// Block-protect window from the four code bits and top/bottom select.
	wire [3:0] code = ctrl_ff[CTRL_CODE_LSB +: 4];
	wire protect_code_bit3 = code[3];
	wire top_bottom = ctrl_ff[CTRL_TB_BIT];
	wire [3:0] shift = code - 4'h1;
	wire [SECT_W:0] span = (code == 4'h0) ? '0 : (12'h001 << shift);
	wire code_all = (code >= CODE_ALL) && protect_code_bit3;
	wire [SECT_W:0] cur_ext = {1'b0, cur_sect};
	wire in_top = cur_ext >= (12'(NUM_SECTORS) - span);
	wire in_bot = cur_ext < span;
	wire bp_prot = (code != 4'h0) && (code_all || (top_bottom ? in_bot : in_top));
	// The pin, or the software bit standing in for it, freezes the area bits while low.
	// Protection itself never waits on the pin, so a high pin cannot open a sector.
	wire bp_locked = !wp_n || !ctrl_ff[CTRL_WPN_BIT];
	wire [4:0] nxt_area = bp_locked ? ctrl_ff[4:0] : pwdata[4:0];
	wire sect_prot = bp_prot || lock_rd[0];

	wire wel = ctrl_ff[CTRL_WEL_BIT];
	wire por_busy = por_ff != 32'h0;
	wire is_array = op_ff inside {FWP_OP_PROG, FWP_OP_SUB_ERASE, FWP_OP_SECT_ERASE,
		FWP_OP_DIE_ERASE};
	assign busy = state_ff != ST_IDLE && state_ff != ST_DONE;
	// Scan outcome: refused, another sector still to visit, or finished and accepted.
	wire scan_refuse = is_array && sect_prot;
	wire scan_more = op_ff == FWP_OP_DIE_ERASE && !scan_last_ff;
	wire scan_ok = state_ff == ST_SCAN && ((op_ff == FWP_OP_LOCK_WR) ? !lock_rd[1] :
		(!scan_refuse && !scan_more));

	// Early verdict before the lock store is consulted.
	fwp_res_t pre_res;
	always_comb begin
		pre_res = FWP_RES_OK;
		if (por_busy) begin
			pre_res = FWP_RES_POR;
		end else if (clk_cnt_ff[2:0] != 3'h0) begin
			pre_res = FWP_RES_BITS;
		end else if (!wel) begin
			pre_res = FWP_RES_NO_WEL;
		end else if (op_ff == FWP_OP_PAGE_ERASE) begin
			pre_res = FWP_RES_BAD;
		end else if (op_ff == FWP_OP_OTP_PROG && addr_ff >= ADDR_W'(OTP_BYTES)) begin
			pre_res = FWP_RES_BAD;
		end
	end

	// Power-on inhibit counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_ff <= 32'hffff_ffff;
		end else if (por_ff == 32'hffff_ffff) begin
			por_ff <= 32'(POR_CNT);
		end else if (por_busy) begin
			por_ff <= por_ff - 32'h1;
		end
	end

	// Software registers; the latch also drops after each accepted command unless a control write in that cycle sets it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			addr_ff <= '0;
			lock_wdata_ff <= 2'h0;
		end else begin
			if (bus_wr && hit_ctrl) begin
				ctrl_ff <= {25'h0, pwdata[6:5], nxt_area};
			end else if (scan_ok) begin
				// Drop the latch once, as the command is accepted, so a fresh enable
				// written afterwards is not wiped while the sequencer sits in done.
				ctrl_ff[CTRL_WEL_BIT] <= 1'b0;
			end
			if (bus_wr && hit_addr && !busy) begin
				addr_ff <= pwdata[ADDR_W-1:0];
			end
			if (bus_wr && hit_lock && !busy) begin
				lock_wdata_ff <= pwdata[1:0];
			end
		end
	end

	// Command sequencer: fetch the lock bits, then check each target sector.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			op_ff <= 3'h0;
			clk_cnt_ff <= 8'h0;
			res_ff <= FWP_RES_OK;
			scan_ff <= '0;
			scan_last_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE, ST_DONE: begin
					if (start) begin
						op_ff <= pwdata[2:0];
						clk_cnt_ff <= pwdata[CMD_CLK_LSB +: 8];
						scan_ff <= '0;
						scan_last_ff <= 1'b0;
						state_ff <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (pre_res != FWP_RES_OK) begin
						res_ff <= pre_res;
						state_ff <= ST_DONE;
					end else begin
						state_ff <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (op_ff == FWP_OP_LOCK_WR) begin
						res_ff <= lock_rd[1] ? FWP_RES_LOCKDN : FWP_RES_OK;
						state_ff <= ST_DONE;
					end else if (is_array && sect_prot) begin
						res_ff <= FWP_RES_PROT;
						state_ff <= ST_DONE;
					end else if (op_ff == FWP_OP_DIE_ERASE && !scan_last_ff) begin
						scan_ff <= scan_ff + 1'b1;
						scan_last_ff <= &scan_ff;
						state_ff <= ST_FETCH;
					end else begin
						res_ff <= FWP_RES_OK;
						state_ff <= ST_DONE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Lock store; only an accepted lock write may change it.
	wire lock_we = state_ff == ST_SCAN && op_ff == FWP_OP_LOCK_WR && !lock_rd[1];
	wire [SECT_W-1:0] next_sect = (op_ff == FWP_OP_DIE_ERASE && state_ff == ST_SCAN) ?
		(die_base | {2'h0, scan_ff + 1'b1}) : cur_sect;
	fwp_lock_mem u_locks (
		.pclk(pclk),
		.presetn(presetn),
		.raddr(next_sect),
		.rdata(lock_rd),
		.we(lock_we),
		.waddr(sector),
		.wdata(lock_wdata_ff)
	);

	// Execute strobe and program data; program can only clear bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_ff <= 1'b0;
			wr_data_ff <= 8'h0;
		end else begin
			// Only the final accepted scan step strobes, once per command.
			exec_ff <= scan_ok && op_ff != FWP_OP_LOCK_WR;
			wr_data_ff <= (op_ff == FWP_OP_PROG || op_ff == FWP_OP_OTP_PROG) ?
				(old_data & new_data) : 8'hff;
		end
	end

	// Read mux.
	wire [31:0] stat_word = {16'h0, 3'h0, segment, 2'h0, die, 1'b0, busy, por_busy,
		res_ff, 2'h0};
	assign prdata = hit_ctrl ? ctrl_ff :
		hit_cmd ? {16'h0, clk_cnt_ff, 5'h0, op_ff} :
		hit_addr ? {5'h0, addr_ff} :
		hit_lock ? {30'h0, lock_wdata_ff} :
		hit_stat ? stat_word :
		hit_diag ? {21'h0, sector} : 32'h0;

	// Refusal one cycle after the scan decides: no strobe, and the result says why.
	sequence s_refused;
		!exec_ff && res_ff == FWP_RES_PROT;
	endsequence

	// A die scan steps back to fetch the next sector, with nothing executed yet.
	sequence s_refetch;
		state_ff == ST_FETCH && !exec_ff;
	endsequence

	// An accepted command strobes once and then falls quiet.
	sequence s_one_pulse;
		exec_ff ##1 !exec_ff;
	endsequence

	// Checks on the accept and refuse paths of the sequencer.
	a_no_wel_exec: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_FETCH && !wel) |=> !exec_ff ##1 !exec_ff)
		else $error("Command ran without write enable");
	a_bits_check: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_FETCH && !por_busy && clk_cnt_ff[2:0] != 3'h0) |=>
		res_ff == FWP_RES_BITS)
		else $error("Partial byte command not discarded");
	a_por_block: assert property (@(posedge pclk) disable iff (!presetn)
		por_busy |-> ##1 !exec_ff)
		else $error("Modification during power-on inhibit");
	a_prot_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && is_array && sect_prot) |=> s_refused)
		else $error("Protected sector not refused");
	a_lockdn_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && op_ff == FWP_OP_LOCK_WR && lock_rd[1]) |->
		!lock_we ##1 res_ff == FWP_RES_LOCKDN)
		else $error("Locked-down sector changed");
	a_prog_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(op_ff == FWP_OP_PROG) |=> (wr_data_ff & ~$past(old_data)) == 8'h0)
		else $error("Program set a bit");
	a_page_erase: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_FETCH && por_ff == 32'h0 && clk_cnt_ff[2:0] == 3'h0 && wel &&
		op_ff == FWP_OP_PAGE_ERASE) |=> res_ff == FWP_RES_BAD)
		else $error("Page erase accepted");
	a_all_code: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && is_array && code >= CODE_ALL) |=> s_refused)
		else $error("High code left a sector open");
	a_top_half: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && is_array && !top_bottom && code == CODE_MAXPART &&
		cur_sect[SECT_W-1]) |=> s_refused)
		else $error("Upper half open under largest top code");
	a_bottom_half: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && is_array && top_bottom && code == CODE_MAXPART &&
		!cur_sect[SECT_W-1]) |=> s_refused)
		else $error("Lower half open under largest bottom code");
	a_area_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_wr && hit_ctrl && bp_locked) |=>
		code == $past(code) && top_bottom == $past(top_bottom))
		else $error("Protected area changed while locked");
	a_die_walk: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_SCAN && scan_more && !scan_refuse) |=> s_refetch)
		else $error("Die scan stopped early");
	a_exec_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(scan_ok && op_ff != FWP_OP_LOCK_WR) |=> s_one_pulse)
		else $error("Accepted command did not strobe once");
	a_wel_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(scan_ok && !(bus_wr && hit_ctrl)) |=> !wel)
		else $error("Write enable kept after accepted command");
endmodule // fwp_top

// [sim/fwp_array_model.sv]
// Array byte model: feeds the current byte and applies approved writes.
// Assumes exec and write data come from the checker's registered outputs.
`timescale 1ns/1ps
module fwp_array_model (
	input wire logic pclk,
	input wire logic exec_ff,
	input wire logic [7:0] wr_data_ff,
	output logic [7:0] old_data
);
	logic [7:0] cell_ff = 8'hf0;

	// The cell moves only on an approved command, so a refused one is seen.
	always @(posedge pclk) begin
		if (exec_ff === 1'b1) cell_ff <= wr_data_ff;
	end

	assign old_data = cell_ff;
endmodule // fwp_array_model

// [sim/tb.sv]
// Self-checking bench for the write-protection checker over APB.
// Assumes the array model beside it and a 5 ns clock.
`timescale 1ns/1ps
module tb
	import fwp_pkg::*;
;
	localparam logic [31:0] W = 32'h60;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wp_n, exec_ff, err, cur_arr;
	logic [7:0] paddr, old_data, new_data, wr_data_ff, nd;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] q[$];
	int n_errors, n_tests, seed, w, s;

	fwp_top #(.POR_CNT(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .old_data(old_data),
		.new_data(new_data), .wp_n(wp_n), .exec_ff(exec_ff), .wr_data_ff(wr_data_ff));
	fwp_array_model arr (.pclk(pclk), .exec_ff(exec_ff), .wr_data_ff(wr_data_ff),
		.old_data(old_data));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One APB transfer; entered just after an edge, held until pready is seen.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Issues one command, notes any array write due, then polls the result.
	task automatic run(input logic [2:0] op, input int sec, input logic [7:0] nclk,
			input logic [31:0] ctl, input logic [2:0] ex, input logic [7:0] wd);
		apb(1'b1, REG_ADDR, 32'(sec) << SECT_LSB);
		apb(1'b1, REG_CTRL, ctl);
		cur_arr = (op != FWP_OP_LOCK_WR);
		if (ex == FWP_RES_OK && cur_arr) q.push_back(wd);
		apb(1'b1, REG_CMD, {16'h0, nclk, 5'h0, op});
		repeat (2) @(posedge pclk);
		rd = 32'h60;
		while (rd[6] | rd[5]) apb(1'b0, REG_STAT, 32'h0);
		chk({29'h0, rd[4:2]}, {29'h0, ex});
		$display("test op %0d sector %0d done", op, sec);
	endtask

	function automatic logic prot(input int t, input int c, input int sc);
		if (c == 0) return 1'b0;
		if (c >= 12) return 1'b1;
		return (t != 0) ? (sc < (1 << (c - 1))) : (sc >= NUM_SECTORS - (1 << (c - 1)));
	endfunction

	// Every executed array write must match the oldest note.
	always @(posedge pclk) begin
		if (exec_ff === 1'b1) begin
			if (q.size() == 0) chk(32'h1, 32'h0);
			else chk({24'h0, wr_data_ff}, {24'h0, q.pop_front()});
		end
	end

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// A hang would otherwise hide every later mismatch.
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	initial begin
		seed = 8;
		presetn = 1'b0;
		wp_n = 1'b1;
		cur_arr = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, new_data} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, CTRL_RST);
		run(FWP_OP_PROG, 9, 8'h20, W, FWP_RES_POR, 8'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		run(FWP_OP_PROG, 9, 8'h1c, W, FWP_RES_BITS, 8'h0);
		run(FWP_OP_PROG, 9, 8'h20, 32'h40, FWP_RES_NO_WEL, 8'h0);
		run(FWP_OP_PAGE_ERASE, 9, 8'h20, W, FWP_RES_BAD, 8'h0);
		run(FWP_OP_SUB_ERASE, 9, 8'h20, W, FWP_RES_OK, 8'hff);
		for (int i = 0; i < 4; i++) begin
			nd = 8'($random(seed));
			new_data <= nd;
			run(FWP_OP_PROG, 9, 8'h20, W, FWP_RES_OK, old_data & nd);
		end
		run(FWP_OP_OTP_PROG, 1, 8'h20, W, FWP_RES_BAD, 8'h0);
		run(FWP_OP_OTP_PROG, 0, 8'h20, W, FWP_RES_OK, old_data & nd);
		run(FWP_OP_REG_WR, 0, 8'h1c, W, FWP_RES_BITS, 8'h0);
		for (int t = 0; t < 2; t++) begin
			for (int c = 0; c < 16; c++) begin
				for (int k = 0; k < 2; k++) begin
					w = (c >= 1 && c <= 11) ? (1 << (c - 1)) : 1;
					s = (t != 0) ? w - 1 + k : NUM_SECTORS - w - k;
					run(FWP_OP_SECT_ERASE, s, 8'h20, 32'(W | (t << 4) | c),
						prot(t, c, s) ? FWP_RES_PROT : FWP_RES_OK, 8'hff);
				end
			end
		end
		run(FWP_OP_SECT_ERASE, 2047, 8'h20, 32'h21, FWP_RES_PROT, 8'h0);
		run(FWP_OP_SECT_ERASE, 2047, 8'h20, W, FWP_RES_PROT, 8'h0);
		wp_n <= 1'b0;
		run(FWP_OP_SECT_ERASE, 2047, 8'h20, W, FWP_RES_PROT, 8'h0);
		wp_n <= 1'b1;
		run(FWP_OP_SECT_ERASE, 2047, 8'h20, W, FWP_RES_OK, 8'hff);
		apb(1'b1, REG_LOCK, 32'h1);
		run(FWP_OP_LOCK_WR, 5, 8'h20, W, FWP_RES_OK, 8'h0);
		run(FWP_OP_PROG, 5, 8'h20, W, FWP_RES_PROT, 8'h0);
		run(FWP_OP_DIE_ERASE, 0, 8'h20, W, FWP_RES_PROT, 8'h0);
		run(FWP_OP_DIE_ERASE, 512, 8'h20, W, FWP_RES_OK, 8'hff);
		chk({30'h0, rd[9:8]}, 32'h1);
		apb(1'b0, REG_DIAG, 32'h0);
		chk(rd, 32'h200);
		apb(1'b1, REG_LOCK, 32'h3);
		run(FWP_OP_LOCK_WR, 5, 8'h20, W, FWP_RES_OK, 8'h0);
		apb(1'b1, REG_LOCK, 32'h0);
		run(FWP_OP_LOCK_WR, 5, 8'h20, W, FWP_RES_LOCKDN, 8'h0);
		run(FWP_OP_PROG, 5, 8'h20, W, FWP_RES_PROT, 8'h0);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		run(FWP_OP_PROG, 5, 8'h20, W, FWP_RES_OK, old_data & nd);
		repeat (4) @(posedge pclk);
		chk(32'(q.size()), 32'h0);
		print_verdict();
	end
endmodule // tb
